// ===== dpr_core.sv
// ddr2 device core: precharge, write auto-precharge, auto refresh and power-down
// Operation
// - write with a10 high self-precharges after burst plus programmed write recovery
// - cs, ras, cas low with we high decodes as auto refresh
// - internal counter supplies refresh row; external address ignored
// - cke sampled low with nop or deselect enters power-down
// - idle banks give precharge power-down, open row gives active; dll per mode
// - power-down disables buffers except clock, odt and cke; inputs ignored
// - cke high with nop or deselect exits power-down
module dpr_core
   import dpr_pkg::*;
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic arst_n_i,
   // command pins
   input wire logic cke_i,
   input wire logic cs_n_i,
   input wire logic ras_n_i,
   input wire logic cas_n_i,
   input wire logic we_n_i,
   input wire logic [dpr_pkg::ROW_W-1:0] addr_i,
   input wire logic [dpr_pkg::BA_W-1:0] ba_i,
   // mode settings from the mode registers
   input wire logic [3:0] wl_i,
   input wire logic [3:0] bl_i,
   input wire logic [3:0] wr_i,
   input wire logic apd_fast_exit_i,
   // bank status
   output logic [dpr_pkg::NUM_BANKS-1:0] bank_open_o,
   output logic [dpr_pkg::NUM_BANKS-1:0] bank_busy_o,
   // refresh status
   output logic refresh_busy_o,
   output logic [dpr_pkg::ROW_W-1:0] refresh_row_o,
   // power-down status
   output logic pd_precharge_o,
   output logic pd_active_o,
   output logic dll_en_o,
   output logic buf_en_o
);
   import dpr_pkg::*;

   localparam int PIN_W = 5 + ROW_W + BA_W;
   localparam logic [CNT_W-1:0] RFC = CNT_W'(TRFC_CYC);

   // pins come from the controller's domain, so two flops before any use
   logic [PIN_W-1:0] pin_meta;
   logic [PIN_W-1:0] pin_sync;
   logic cke;
   logic cke_prev;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic [ROW_W-1:0] addr;
   logic [BA_W-1:0] ba;
   logic a10;
   dpr_cmd_e cmd;
   dpr_state_e state;
   dpr_state_e next_state;
   logic take;
   logic take_act;
   logic take_pre;
   logic take_wap;
   logic take_ref;
   logic any_open;
   logic [CNT_W-1:0] rfc_cnt;
   logic [ROW_W-1:0] ref_row;
   logic [CNT_W-1:0] wap_total;
   logic [NUM_BANKS-1:0] open_vec;
   logic [NUM_BANKS-1:0] busy_vec;

   // bank match shared by the activate, precharge and write strobes
   function automatic logic bank_hit(input logic [BA_W-1:0] sel, input int idx);
      return sel == BA_W'(idx);
   endfunction

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pin_meta <= '0;
         pin_sync <= '0;
      end else begin
         pin_meta <= {cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, addr_i, ba_i};
         pin_sync <= pin_meta;
      end
   end

   assign {cke, cs_n, ras_n, cas_n, we_n, addr, ba} = pin_sync;
   assign a10 = addr[10];

   assign cmd = dpr_decode(cs_n, ras_n, cas_n, we_n);

   // resets low so nothing is taken until cke has been seen high on two edges
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cke_prev <= 1'b0;
      end else begin
         cke_prev <= cke;
      end
   end

   // commands only taken while running with cke high on both edges
   assign take = (state == ST_RUN) && cke_prev && cke && !refresh_busy_o;

   assign take_act = take && (cmd == CMD_ACT);
   assign take_pre = take && (cmd == CMD_PRE);
   assign take_wap = take && (cmd == CMD_WR);
   assign take_ref = take && (cmd == CMD_REF);

   assign wap_total = CNT_W'(wl_i) + CNT_W'(bl_i >> 1) + CNT_W'(wr_i);

   dpr_bank_if bif[NUM_BANKS]();

   for (genvar g = 0; g < NUM_BANKS; g++) begin : g_bank
      assign bif[g].act = take_act && bank_hit(ba, g);
      assign bif[g].pre = take_pre && (a10 || bank_hit(ba, g));
      assign bif[g].wap = take_wap && a10 && bank_hit(ba, g);
      assign bif[g].wap_cnt = wap_total;
      assign open_vec[g] = bif[g].open;
      assign busy_vec[g] = bif[g].busy;
      dpr_bank u_bank (
         .mclk_i(mclk_i),
         .arst_n_i(arst_n_i),
         .bus(bif[g])
      );
   end

   assign any_open = |open_vec;
   assign bank_open_o = open_vec;
   assign bank_busy_o = busy_vec;

   // internal row counter, address pins unused
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ref_row <= REF_ROW_RST;
      end else if (take_ref) begin
         ref_row <= ref_row + ROW_W'(1);
      end
   end

   // refresh busy blocks every command; spacing after refresh is the controller's duty
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rfc_cnt <= CNT_ZERO;
      end else if (take_ref) begin
         rfc_cnt <= RFC;
      end else if (rfc_cnt != CNT_ZERO) begin
         rfc_cnt <= rfc_cnt - CNT_ONE;
      end
   end

   assign refresh_busy_o = (rfc_cnt != CNT_ZERO);
   assign refresh_row_o = ref_row;

   // entry and exit, both need nop or deselect
   always_comb begin
      next_state = state;
      unique case (state)
         ST_RUN: begin
            if (cke_prev && !cke && (cmd == CMD_NOP)) begin
               next_state = any_open ? ST_APD : ST_PPD;
            end
         end
         ST_PPD, ST_APD: begin
            if (!cke_prev && cke && (cmd == CMD_NOP)) begin
               next_state = ST_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state <= ST_RUN;
      end else begin
         state <= next_state;
      end
   end

   // power-down kind follows open rows at entry
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pd_precharge_o <= 1'b0;
         pd_active_o <= 1'b0;
      end else begin
         pd_precharge_o <= (next_state == ST_PPD);
         pd_active_o <= (next_state == ST_APD);
      end
   end

   // dll on while running, off in power-down except fast-exit active power-down
   // exit choice is read live; it only changes by mode set, which power-down refuses
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         dll_en_o <= 1'b1;
      end else begin
         dll_en_o <= (next_state == ST_RUN) || ((next_state == ST_APD) && apd_fast_exit_i);
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         buf_en_o <= 1'b1;
      end else begin
         buf_en_o <= (next_state == ST_RUN);
      end
   end
endmodule // dpr_core

// ===== dpr_pkg.sv
// constants, commands and states for the precharge, refresh and power-down core
package dpr_pkg;
   localparam int NUM_BANKS = 8;
   localparam int BA_W = 3;
   localparam int ROW_W = 14;
   localparam int CNT_W = 8;
   localparam int CLK_PERIOD_NS = 100;
   // precharge time and refresh cycle time, in ns
   localparam int TRP_NS = 15;
   localparam int TRFC_NS = 128;
   localparam int TRP_RAW = (TRP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TRP_CYC = (TRP_RAW < 1) ? 1 : TRP_RAW;
   localparam int TRPALL_CYC = TRP_CYC + 1;
   localparam int TRFC_RAW = (TRFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TRFC_CYC = (TRFC_RAW < 1) ? 1 : TRFC_RAW;
   localparam logic [ROW_W-1:0] REF_ROW_RST = 14'h0000;
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

   typedef enum logic [6:0] {
      CMD_NOP = 7'h01,
      CMD_ACT = 7'h02,
      CMD_RD = 7'h04,
      CMD_WR = 7'h08,
      CMD_PRE = 7'h10,
      CMD_REF = 7'h20,
      CMD_MRS = 7'h40
   } dpr_cmd_e;

   typedef enum logic [2:0] {
      ST_RUN = 3'h1,
      ST_PPD = 3'h2,
      ST_APD = 3'h4
   } dpr_state_e;

   // deselect counts as a nop
   function automatic dpr_cmd_e dpr_decode(input logic cs_n, input logic ras_n,
                                           input logic cas_n, input logic we_n);
      dpr_cmd_e c;
      c = CMD_NOP;
      if (!cs_n) begin
         unique case ({ras_n, cas_n, we_n})
            3'b011: c = CMD_ACT;
            3'b101: c = CMD_RD;
            3'b100: c = CMD_WR;
            3'b010: c = CMD_PRE;
            3'b001: c = CMD_REF;
            3'b000: c = CMD_MRS;
            default: c = CMD_NOP;
         endcase
      end
      return c;
   endfunction
endpackage

// ===== dpr_bank_if.sv
// per-bank control and status between the core and one bank tracker
interface dpr_bank_if;
   import dpr_pkg::*;
   logic act;
   logic pre;
   logic wap;
   logic [CNT_W-1:0] wap_cnt;
   logic open;
   logic busy;
   modport core (output act, output pre, output wap, output wap_cnt, input open, input busy);
   modport bank (input act, input pre, input wap, input wap_cnt, output open, output busy);
endinterface

// ===== dpr_bank.sv
// one bank: row open flag, write auto-precharge delay, precharge period
module dpr_bank (
   // clock and reset
   input wire logic mclk_i,
   input wire logic arst_n_i,
   // core side
   dpr_bank_if.bank bus
);
   import dpr_pkg::*;

   localparam logic [CNT_W-1:0] RPALL = CNT_W'(TRPALL_CYC);

   logic open;
   logic ap_pend;
   logic [CNT_W-1:0] ap_cnt;
   logic [CNT_W-1:0] rp_cnt;
   logic ap_fire;

   assign ap_fire = ap_pend && (ap_cnt == CNT_ONE);

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ap_pend <= 1'b0;
         ap_cnt <= CNT_ZERO;
      end else if (bus.wap) begin
         ap_pend <= 1'b1;
         ap_cnt <= (bus.wap_cnt == CNT_ZERO) ? CNT_ONE : bus.wap_cnt;
      end else if (ap_fire || bus.pre) begin
         ap_pend <= 1'b0;
         ap_cnt <= CNT_ZERO;
      end else if (ap_pend) begin
         ap_cnt <= ap_cnt - CNT_ONE;
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         open <= 1'b0;
      end else if (bus.act) begin
         open <= 1'b1;
      end else if (bus.pre || ap_fire) begin
         open <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rp_cnt <= CNT_ZERO;
      end else if (bus.pre || ap_fire) begin
         rp_cnt <= RPALL;
      end else if (rp_cnt != CNT_ZERO) begin
         rp_cnt <= rp_cnt - CNT_ONE;
      end
   end

   assign bus.open = open;
   assign bus.busy = ap_pend || (rp_cnt != CNT_ZERO);
endmodule // dpr_bank

// ===== dpr_core_asserts.sv
// concurrent checks on the device core ports
module dpr_core_asserts
   import dpr_pkg::*;
(
   // clock, reset and pins
   input logic mclk_i,
   input logic arst_n_i,
   input logic cke_i,
   input logic cs_n_i,
   input logic ras_n_i,
   input logic cas_n_i,
   input logic we_n_i,
   input logic [dpr_pkg::ROW_W-1:0] addr_i,
   input logic apd_fast_exit_i,
   // status
   input logic [dpr_pkg::NUM_BANKS-1:0] bank_open_o,
   input logic [dpr_pkg::NUM_BANKS-1:0] bank_busy_o,
   input logic refresh_busy_o,
   input logic [dpr_pkg::ROW_W-1:0] refresh_row_o,
   input logic pd_precharge_o,
   input logic pd_active_o,
   input logic dll_en_o,
   input logic buf_en_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic nop, rfr, pall, rdy, pd;
   // pins lead the state by the two-flop synchroniser, hence the ##2
   assign nop = cs_n_i | (ras_n_i & cas_n_i & we_n_i);
   assign rfr = ~(cs_n_i | ras_n_i | cas_n_i) & we_n_i & cke_i;
   assign pall = ~(cs_n_i | ras_n_i | we_n_i) & cas_n_i & addr_i[10] & cke_i;
   assign rdy = buf_en_o & ~refresh_busy_o;
   assign pd = pd_precharge_o | pd_active_o;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!arst_n_i);
   property p_ref; rfr ##2 rdy |=> refresh_busy_o [*2] ##1 !refresh_busy_o; endproperty
   a_ref: assert property (p_ref) else $error("refresh length");
   property p_row; $rose(refresh_busy_o) |-> refresh_row_o == $past(refresh_row_o) + 14'h1; endproperty
   a_row: assert property (p_row) else $error("refresh row step");
   property p_pall; pall ##2 rdy |=> bank_open_o == '0 && bank_busy_o == '1 ##1 bank_busy_o == '1; endproperty
   a_pall: assert property (p_pall) else $error("precharge all");
   property p_pden;
      $past(cke_i) && !cke_i && nop ##2 rdy |=> !buf_en_o && pd_active_o == ($past(bank_open_o) != '0)
         && pd_precharge_o == ($past(bank_open_o) == '0);
   endproperty
   a_pden: assert property (p_pden) else $error("power-down entry");
   property p_dll; pd |-> dll_en_o == (pd_active_o && apd_fast_exit_i); endproperty
   a_dll: assert property (p_dll) else $error("dll mode");
   property p_buf; buf_en_o != pd; endproperty
   a_buf: assert property (p_buf) else $error("buffer enable");
   // a pending auto-precharge may still close a row in power-down, but none may open
   property p_ign; !buf_en_o [*2] |=> $stable(refresh_row_o) && (bank_open_o & ~$past(bank_open_o)) == '0; endproperty
   a_ign: assert property (p_ign) else $error("command in power-down");
   property p_pdex; !$past(cke_i) && cke_i && nop ##2 !buf_en_o |=> buf_en_o && dll_en_o && !pd; endproperty
   a_pdex: assert property (p_pdex) else $error("power-down exit");
endmodule // dpr_core_asserts

bind dpr_core dpr_core_asserts i_chk (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .cke_i(cke_i), .cs_n_i(cs_n_i),
   .ras_n_i(ras_n_i), .cas_n_i(cas_n_i), .we_n_i(we_n_i), .addr_i(addr_i), .apd_fast_exit_i(apd_fast_exit_i),
   .bank_open_o(bank_open_o), .bank_busy_o(bank_busy_o), .refresh_busy_o(refresh_busy_o),
   .refresh_row_o(refresh_row_o), .pd_precharge_o(pd_precharge_o), .pd_active_o(pd_active_o),
   .dll_en_o(dll_en_o), .buf_en_o(buf_en_o));

// ===== dpr_ctrl_model.sv
// controller stand-in that drives cke, command, address and bank pins
module dpr_ctrl_model (
   // clock
   input logic mclk_i,
   // pins, command as cs ras cas we
   output logic cke_o,
   output logic [3:0] cmd_n_o,
   output logic [dpr_pkg::ROW_W-1:0] addr_o,
   output logic [dpr_pkg::BA_W-1:0] ba_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial {cke_o, cmd_n_o, addr_o, ba_o} = {1'h0, 4'h7, 17'h0};
   task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic a10, input int gap);
      cmd_n_o = c;
      ba_o = b;
      addr_o = (14'($urandom) & 14'h3bff) | {3'h0, a10, 10'h000};
      @(negedge mclk_i);
      if (gap > 0) cmd_n_o = 4'h7;
      repeat (gap) @(negedge mclk_i);
   endtask
   // cke moves under nop, then holds
   task automatic ck(input logic v);
      cke_o = v;
      repeat (6) @(negedge mclk_i);
   endtask
endmodule // dpr_ctrl_model

// ===== tb_dpr_core.sv
// self-checking bench for the ddr2 device core
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin err_total++; $display("mismatch %s exp %h got %h", n, e, s); end end
module tb_dpr_core;
   timeunit 1ns;
   timeprecision 1ns;
   import dpr_pkg::*;
   logic mclk_i = 1'h0, arst_n_i = 1'h0, apd = 1'h0;
   logic [3:0] wl = 4'h1, bl = 4'h4, wr = 4'h2, c;
   logic cke, pp, pa, dl, be;
   logic [2:0] ba, b;
   logic [13:0] addr, row;
   logic [7:0] bo;
   logic [25:0] st, last, e_st;
   logic [57:0] q[$];
   int err_total = 0, num_checks = 0, cyc = 0;
   // controller figures: no additive latency, read-to-precharge time arbitrary
   localparam int AL = 0, TRTP_NS = 8;
   localparam int RTP = (TRTP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   dpr_core i_dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .cke_i(cke), .cs_n_i(c[3]), .ras_n_i(c[2]),
      .cas_n_i(c[1]), .we_n_i(c[0]), .addr_i(addr), .ba_i(ba), .wl_i(wl), .bl_i(bl), .wr_i(wr),
      .apd_fast_exit_i(apd), .bank_open_o(bo), .bank_busy_o(), .refresh_busy_o(), .refresh_row_o(row),
      .pd_precharge_o(pp), .pd_active_o(pa), .dll_en_o(dl), .buf_en_o(be));
   dpr_ctrl_model i_ctl (.mclk_i(mclk_i), .cke_o(cke), .cmd_n_o(c), .addr_o(addr), .ba_o(ba));
   always #50 mclk_i = ~mclk_i;
   assign st = {pp, pa, dl, be, bo, row};
   task automatic give_verdict();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc > 2000) begin
         err_total++;
         give_verdict();
      end
   end
   // each status change takes the oldest note: value and earliest cycle
   always @(negedge mclk_i) begin
      if (arst_n_i && st !== last) begin
         if (q.size() == 0) `CHK("status", last, st)
         else begin
            `CHK("status", q[0][25:0], st)
            `CHK("timing", 1'h1, cyc >= q[0][57:26])
            void'(q.pop_front());
         end
      end
      last = st;
   end
   task automatic cmd(input logic [3:0] k, input logic a10, input int gap, input int d);
      if (d > 0) q.push_back({cyc + d, e_st});
      i_ctl.issue(k, b, a10, gap);
   endtask
   task automatic pdn(input logic v, input logic [3:0] m);
      e_st[25:22] = m;
      q.push_back({cyc + 3, e_st});
      i_ctl.ck(v);
   endtask
   initial begin
      void'($urandom(87680));
      e_st = 26'h0c00000;
      repeat (20) @(negedge mclk_i);
      arst_n_i = 1'h1;
      `CHK("reset", e_st, st)
      i_ctl.ck(1'h1);
      repeat (2) begin
         b = 3'($urandom);
         e_st[14 + b] = 1'h1;
         cmd(4'h3, 1'h0, 1, 3);
         b = b ^ 3'h1;
         e_st[14 + b] = 1'h1;
         cmd(4'h3, 1'h0, 1, 3);
         // read, then precharge after the spacing
         cmd(4'h5, 1'h0, AL + bl / 2 + ((RTP > 2) ? RTP : 2) - 3, 0);
         e_st[14 + b] = 1'h0;
         cmd(4'h2, 1'h0, 0, 3);
         e_st[21:14] = 8'h00;
         cmd(4'h2, 1'h1, 5, 3);
      end
      // second refresh while busy is dropped
      e_st[13:0] += 14'h1;
      cmd(4'h1, 1'h0, 0, 3);
      cmd(4'h1, 1'h0, 3, 0);
      e_st[13:0] += 14'h1;
      cmd(4'h1, 1'h1, 4, 3);
      repeat (2) begin
         b = 3'($urandom);
         wl = 4'(1 + $urandom % 4);
         bl = ($urandom % 2) ? 4'h8 : 4'h4;
         wr = 4'(2 + $urandom % 4);
         e_st[14 + b] = 1'h1;
         cmd(4'h3, 1'h0, 4, 3);
         e_st[14 + b] = 1'h0;
         cmd(4'h4, 1'h1, 24, 3 + wl + bl / 2 + wr);
      end
      pdn(1'h0, 4'h8);
      cmd(4'h3, 1'h0, 4, 0);
      pdn(1'h1, 4'h3);
      // dll reset by mode set after exit
      cmd(4'h0, 1'h0, 4, 0);
      for (int i = 0; i < 2; i++) begin
         apd = i[0];
         b = 3'($urandom);
         e_st[14 + b] = 1'h1;
         cmd(4'h3, 1'h0, 5, 3);
         // open row, dll per exit mode
         pdn(1'h0, {2'h1, apd, 1'h0});
         pdn(1'h1, 4'h3);
         e_st[21:14] = 8'h00;
         cmd(4'h2, 1'h1, 5, 3);
      end
      for (int i = 0; i < 40 && q.size() > 0; i++) @(negedge mclk_i);
      `CHK("pending", 0, q.size())
      give_verdict();
   end
endmodule // tb_dpr_core
